// ===== design/aptc_consts.svh
// Purpose: Constants for the ADC pair trigger control block
// Assumes: 16-bit register port, word index addressing
// Notes:   Offsets are register indices on the plain register port
`ifndef APTC_CONSTS_SVH
`define APTC_CONSTS_SVH

// Register indices
`define APTC_OFS_CTRL_A   4'h0
`define APTC_OFS_CTRL_B   4'h1
`define APTC_OFS_CTRL_C   4'h2
`define APTC_OFS_STATUS   4'h3
`define APTC_OFS_MASK     4'h4

// Field positions inside each byte of a control register
`define APTC_BIT_IRQ_EN   3'h7
`define APTC_BIT_PEND     3'h6
`define APTC_BIT_SOFT     3'h5
`define APTC_SRC_MSB      3'h4
`define APTC_SRC_LSB      3'h0

// Reset values
`define APTC_RST_CTRL     16'h0000
`define APTC_RST_IRQ      6'h00

// Trigger source codes
`define APTC_SRC_OFF      5'h00
`define APTC_SRC_SOFT     5'h01
`define APTC_SRC_GSOFT    5'h02
`define APTC_SRC_SPECIAL  5'h03
`define APTC_SRC_PRI_LO   5'h04
`define APTC_SRC_PRI_HI   5'h0B
`define APTC_SRC_TMR1     5'h0C
`define APTC_SRC_SEC_SPEC 5'h0D
`define APTC_SRC_SEC_LO   5'h0E
`define APTC_SRC_SEC_HI   5'h16
`define APTC_SRC_CL_LO    5'h17
`define APTC_SRC_CL_HI    5'h1E
`define APTC_SRC_TMR2     5'h1F

`endif

// ===== design/aptc_pkg.sv
// Purpose: Types for the ADC pair trigger control block
// Assumes: Constants live in aptc_consts.svh
// Notes:   One pair byte matches the register byte layout bit for bit
package aptc_pkg;

  // One pair's control byte: enable, pending, soft trigger, source
  typedef struct packed {
    logic       irq_enable;
    logic       pending;
    logic       soft_trigger;
    logic [4:0] source_select;
  } aptc_pair_s;

  // Trigger producers on the far side, all on the block clock
  typedef struct packed {
    logic       global_soft;
    logic       pwm_special;
    logic [7:0] pwm_primary;
    logic       timer1_period;
    logic       pwm_sec_special;
    logic [8:0] pwm_secondary;
    logic [7:0] pwm_current_limit;
    logic       timer2_period;
  } aptc_trig_s;

  // Whole block state
  typedef struct packed {
    aptc_pair_s [5:0] pair;
    logic [5:0]       status;
    logic [5:0]       mask;
    logic [5:0]       pair_irq;
    logic [15:0]      rdata;
  } aptc_state_s;

endpackage

// ===== design/aptc_top.sv
// Purpose: Conversion trigger control for ADC pairs 2 to 7
// Assumes: Trigger inputs and completion pulses come from logic on clk
// Notes:   Pair index 0..5 inside the block stands for pairs 2..7
// Behaviour
// [R1] Interrupt enable set: request raised when that pair's conversion finishes; clear: none.
// [R2] Pending flag sets when selected trigger asserts, clears when conversion completes.
// [R3] Writing soft trigger one requests conversion, only with a software source selected.
// [R4] Hardware clears the soft trigger bit in the action that sets pending; code clears it only when a software code fires.
// [R5] Two pairs per register; upper byte higher pair, source fields bits 12-8 and 4-0.
// [R6] Pair n converts inputs 2n and 2n+1; registers hold pairs 2-3, 4-5, 6-7.
// [R7] Code 0 disables, code 1 individual software, code 2 global software trigger.
// [R8] Code 3 PWM special event; codes 4 to 11 PWM primary triggers 1 to 8.
// [R9] Code 12 timer 1 period match; code 31 timer 2 period match.
// [R10] Code 13 secondary special event; codes 14 to 22 PWM secondary triggers 1 to 9.
// [R11] Codes 23 to 30 PWM current-limit triggers 1 to 8.
// [R12] Software selects software source first; engine defers requests while busy.
// [R13] All control and source bits reset to zero, so nothing converts.
// [R14] Each pair's pending flag stays set independently until its own conversion finishes.
`timescale 1ns/1ns
`include "aptc_consts.svh"
`default_nettype none

module aptc_top #(
  parameter int ADDR_W = 4
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [15:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [15:0]         rdata,
  input  wire aptc_pkg::aptc_trig_s trig,
  input  wire logic [5:0]          conv_done,
  output logic      [5:0]          conv_pending,
  output logic      [5:0]          pair_irq,
  output logic                     irq
);

  aptc_pkg::aptc_state_s state;
  aptc_pkg::aptc_state_s next_state;

  aptc_pkg::aptc_pair_s [5:0] pair_next;     // Next byte from each pair slice
  logic                 [5:0] pair_finish;   // Done seen while the pair is outstanding
  logic                 [5:0] byte_wr;       // Write strobe for each pair byte

  // Byte write strobes; each control register feeds two neighbouring pairs
  always_comb begin
    byte_wr = 6'h00;
    if (wr && addr == ADDR_W'(`APTC_OFS_CTRL_A)) begin
      byte_wr = 6'h03;                                           // [R5] [R6]
    end else if (wr && addr == ADDR_W'(`APTC_OFS_CTRL_B)) begin
      byte_wr = 6'h0C;                                           // [R5] [R6]
    end else if (wr && addr == ADDR_W'(`APTC_OFS_CTRL_C)) begin
      byte_wr = 6'h30;                                           // [R5] [R6]
    end else begin
      byte_wr = 6'h00;
    end
  end

  // One slice per pair; even slices take the low byte, odd ones the high byte
  for (genvar g = 0; g < 6; g++) begin : g_pair
    aptc_pair_next #(
      .BYTE_W (8)
    ) i_aptc_pair_next (
      .wr_byte (byte_wr[g]),
      .wbyte   (wdata[8*(g%2) +: 8]),                            // [R5]
      .cur     (state.pair[g]),
      .trig    (trig),
      .done    (conv_done[g]),
      .nxt     (pair_next[g]),
      .finish  (pair_finish[g])
    );
  end

  // Next state: pair bytes, requests, sticky status, mask and read data
  always_comb begin
    next_state          = state;
    next_state.pair     = pair_next;                             // [R2] [R4] [R14]
    next_state.pair_irq = 6'h00;
    next_state.rdata    = 16'h0000;
    // Only an enabled pair whose own conversion ends raises a request
    for (int i = 0; i < 6; i++) begin
      next_state.pair_irq[i] = pair_finish[i] & state.pair[i].irq_enable; // [R1]
    end
    // Mask keeps six bits, one per pair
    if (wr && addr == ADDR_W'(`APTC_OFS_MASK)) begin
      next_state.mask = wdata[5:0];
    end
    // Sticky status: write one clears, a same cycle event wins
    if (wr && addr == ADDR_W'(`APTC_OFS_STATUS)) begin
      next_state.status = state.status & ~wdata[5:0];
    end
    next_state.status = next_state.status | next_state.pair_irq;
    // Read data stands one cycle after the read strobe only
    if (rd) begin
      if (addr == ADDR_W'(`APTC_OFS_CTRL_A)) begin
        next_state.rdata = {state.pair[1], state.pair[0]};       // [R5] [R6]
      end else if (addr == ADDR_W'(`APTC_OFS_CTRL_B)) begin
        next_state.rdata = {state.pair[3], state.pair[2]};       // [R5] [R6]
      end else if (addr == ADDR_W'(`APTC_OFS_CTRL_C)) begin
        next_state.rdata = {state.pair[5], state.pair[4]};       // [R5] [R6]
      end else if (addr == ADDR_W'(`APTC_OFS_STATUS)) begin
        next_state.rdata = {10'h000, state.status};
      end else if (addr == ADDR_W'(`APTC_OFS_MASK)) begin
        next_state.rdata = {10'h000, state.mask};
      end else begin
        next_state.rdata = 16'h0000;
      end
    end
  end

  // State register; everything clears so no pair converts after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      state.pair     <= 48'(`APTC_RST_CTRL);                     // [R13]
      state.status   <= `APTC_RST_IRQ;
      state.mask     <= `APTC_RST_IRQ;
      state.pair_irq <= `APTC_RST_IRQ;
      state.rdata    <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  // Outputs
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      conv_pending[i] = state.pair[i].pending;                   // [R12]
    end
  end
  assign pair_irq = state.pair_irq;
  assign rdata    = state.rdata;
  // Level interrupt while any unmasked sticky bit stands
  assign irq      = |(state.status & state.mask);

endmodule

// One pair slice: source decode, pending flag, soft trigger clear and byte write
module aptc_pair_next #(
  parameter int BYTE_W = 8
) (
  input  wire logic                 wr_byte,
  input  wire logic [BYTE_W-1:0]    wbyte,
  input  wire aptc_pkg::aptc_pair_s cur,
  input  wire aptc_pkg::aptc_trig_s trig,
  input  wire logic                 done,
  output var  aptc_pkg::aptc_pair_s nxt,
  output logic                      finish
);

  logic hit;        // Selected trigger seen this cycle
  logic soft_src;   // Source is one of the two software codes

  // Source decode, one code a line so every producer can be traced
  always_comb begin
    hit = 1'b0;
    case (cur.source_select)
      `APTC_SRC_OFF:      hit = 1'b0;                                // [R7] [R13]
      `APTC_SRC_SOFT:     hit = cur.soft_trigger;                    // [R7] [R3]
      `APTC_SRC_GSOFT:    hit = cur.soft_trigger | trig.global_soft; // [R7] [R3]
      `APTC_SRC_SPECIAL:  hit = trig.pwm_special;                    // [R8]
      `APTC_SRC_PRI_LO:   hit = trig.pwm_primary[0];                 // [R8]
      5'h05:              hit = trig.pwm_primary[1];
      5'h06:              hit = trig.pwm_primary[2];
      5'h07:              hit = trig.pwm_primary[3];
      5'h08:              hit = trig.pwm_primary[4];
      5'h09:              hit = trig.pwm_primary[5];
      5'h0A:              hit = trig.pwm_primary[6];
      `APTC_SRC_PRI_HI:   hit = trig.pwm_primary[7];
      `APTC_SRC_TMR1:     hit = trig.timer1_period;                  // [R9]
      `APTC_SRC_SEC_SPEC: hit = trig.pwm_sec_special;                // [R10]
      `APTC_SRC_SEC_LO:   hit = trig.pwm_secondary[0];               // [R10]
      5'h0F:              hit = trig.pwm_secondary[1];
      5'h10:              hit = trig.pwm_secondary[2];
      5'h11:              hit = trig.pwm_secondary[3];
      5'h12:              hit = trig.pwm_secondary[4];
      5'h13:              hit = trig.pwm_secondary[5];
      5'h14:              hit = trig.pwm_secondary[6];
      5'h15:              hit = trig.pwm_secondary[7];
      `APTC_SRC_SEC_HI:   hit = trig.pwm_secondary[8];
      `APTC_SRC_CL_LO:    hit = trig.pwm_current_limit[0];           // [R11]
      5'h18:              hit = trig.pwm_current_limit[1];
      5'h19:              hit = trig.pwm_current_limit[2];
      5'h1A:              hit = trig.pwm_current_limit[3];
      5'h1B:              hit = trig.pwm_current_limit[4];
      5'h1C:              hit = trig.pwm_current_limit[5];
      5'h1D:              hit = trig.pwm_current_limit[6];
      `APTC_SRC_CL_HI:    hit = trig.pwm_current_limit[7];
      `APTC_SRC_TMR2:     hit = trig.timer2_period;                  // [R9]
      default:            hit = 1'b0;
    endcase
  end

  // Both software codes drop the soft bit when they fire
  assign soft_src = (cur.source_select == `APTC_SRC_SOFT) ||
                    (cur.source_select == `APTC_SRC_GSOFT);

  // A done pulse only counts while this pair is outstanding
  assign finish = done & cur.pending;                            // [R14]

  // Next byte; a software write beats the hardware soft clear
  always_comb begin
    nxt = cur;
    // A trigger in the finishing cycle keeps the pair pending
    nxt.pending = (cur.pending & ~finish) | hit;                 // [R2] [R14] [R12]
    if (hit && soft_src) begin
      nxt.soft_trigger = 1'b0;                                   // [R4]
    end
    // Pending is hardware owned, so a write leaves it alone
    if (wr_byte) begin
      nxt.irq_enable    = wbyte[`APTC_BIT_IRQ_EN];               // [R1] [R5]
      nxt.soft_trigger  = wbyte[`APTC_BIT_SOFT];                 // [R3]
      nxt.source_select = wbyte[`APTC_SRC_MSB:`APTC_SRC_LSB];    // [R5]
    end
  end

endmodule

`default_nettype wire

// ===== verif/aptc_engine.sv
// Purpose: Conversion engine model on the far side of the trigger block
// Assumes: One conversion at a time, lowest pending pair first
// Notes:   dly of 2 or more keeps a done pulse off a flag already falling
`timescale 1ns/1ns
`default_nettype none
module aptc_engine (
  input  wire logic [3:0] dly,
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [5:0] conv_pending,
  output logic      [5:0] conv_done
);
  logic [3:0] cnt;
  // Busy engine defers later requests until the current one ends
  always_ff @(posedge clk) begin
    conv_done <= 6'h00;
    if (srst || conv_pending == 6'h00 || conv_done != 6'h00) begin
      cnt <= 4'h0;
    end else if (cnt >= dly) begin
      conv_done <= conv_pending & ~(conv_pending - 6'h01);
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== verif/aptc_asserts.sv
// Purpose: Port-level checks of the pair trigger block
// Assumes: Triggers and done pulses on clk
// Notes:   Pair index 0 stands for pair two
`timescale 1ns/1ns
`include "aptc_consts.svh"
`default_nettype none
module aptc_asserts #(
  parameter int ADDR_W = 4
) (
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic [ADDR_W-1:0]    addr,
  input wire logic [15:0]          wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input wire logic [15:0]          rdata,
  input wire aptc_pkg::aptc_trig_s trig,
  input wire logic [5:0]           conv_done,
  input wire logic [5:0]           conv_pending,
  input wire logic [5:0]           pair_irq,
  input wire logic                 irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Write of pair two's byte while it is idle
  sequence s_pair_wr(logic [5:0] v);
    wr && addr == ADDR_W'(`APTC_OFS_CTRL_A) && wdata[5:0] == v && !conv_pending[0];
  endsequence
  a_read_idle: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not idle");
  a_unmapped_zero: assert property (rd && addr > ADDR_W'(4) |=> rdata == 16'h0000) else $error("unmapped read");
  a_soft_fire: assert property (s_pair_wr(6'h21) |=> ##1 conv_pending[0]) else $error("soft trigger lost");
  a_off_quiet: assert property (s_pair_wr(6'h20) |=> ##1 !conv_pending[0] [*3]) else $error("code zero fired");
  a_pend_hold: assert property (($past(conv_pending & ~conv_done) & ~conv_pending) == 6'h00) else $error("flag lost");
  a_done_drop: assert property (!wr && trig == '0 |=> ($past(conv_done) & conv_pending) == 6'h00) else $error("flag held");
  a_irq_cause: assert property ((pair_irq & ~$past(conv_done & conv_pending)) == 6'h00) else $error("stray request");
  a_irq_pulse: assert property (pair_irq != 6'h00 |=> (pair_irq & $past(pair_irq)) == 6'h00) else $error("long pulse");
  a_mask_off: assert property (wr && addr == ADDR_W'(`APTC_OFS_MASK) && wdata[5:0] == 6'h00 |=> !irq) else $error("irq");
endmodule
bind aptc_top aptc_asserts #(.ADDR_W(ADDR_W)) i_aptc_asserts (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .trig,
  .conv_done, .conv_pending, .pair_irq, .irq);
`default_nettype wire

// ===== verif/aptc_top_tb.sv
// Purpose: Self-checking bench for the pair trigger block
// Assumes: Engine model answers after dly cycles
// Notes:   Inputs change right after a rising edge, outputs read at the falling edge
`timescale 1ns/1ns
`default_nettype none
module aptc_top_tb;
  logic                 clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic [3:0]           addr = 4'h0;
  logic [3:0]           dly = 4'h8;
  logic [15:0]          wdata = 16'h0000;
  logic [15:0]          rdata;
  aptc_pkg::aptc_trig_s trig = '0;
  logic [5:0]           conv_done;
  logic [5:0]           conv_pending;
  logic [5:0]           pair_irq;
  logic                 irq;
  int                   n_mismatch = 0;
  int                   n_checks = 0;
  int                   cyc = 0;
  int                   p;
  always #2 clk = ~clk;
  aptc_top #(.ADDR_W(4)) i_aptc_top (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .trig, .conv_done,
    .conv_pending, .pair_irq, .irq);
  aptc_engine i_aptc_engine (.dly, .clk, .srst, .conv_pending, .conv_done);
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes drop one edge early so two tasks never drive them in one step
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic pulse(input aptc_pkg::aptc_trig_s t);
    trig <= t;
    @(posedge clk);
    trig <= '0;
    @(posedge clk);
  endtask
  // The request pulse stands in the cycle in which pending first reads low
  task automatic wait_pend(input logic [5:0] e, input logic [5:0] ie = 6'h00);
    @(negedge clk);
    for (int i = 0; i < 40 && conv_pending !== e; i++) @(negedge clk);
    chk({10'h000, conv_pending}, {10'h000, e});
    chk({10'h000, pair_irq}, {10'h000, ie});
    @(posedge clk);
  endtask
  // One producer per source code from 2 to 31
  function automatic aptc_pkg::aptc_trig_s src_trig(input int c);
    aptc_pkg::aptc_trig_s t;
    t = '0;
    if (c == 2) t.global_soft = 1'b1;
    else if (c == 3) t.pwm_special = 1'b1;
    else if (c <= 11) t.pwm_primary[c-4] = 1'b1;
    else if (c == 12) t.timer1_period = 1'b1;
    else if (c == 13) t.pwm_sec_special = 1'b1;
    else if (c <= 22) t.pwm_secondary[c-14] = 1'b1;
    else if (c <= 30) t.pwm_current_limit[c-23] = 1'b1;
    else t.timer2_period = 1'b1;
    return t;
  endfunction
  // Hang guard, the run needs about 560 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wr_reg(4'h5, 16'hFFFF);
    for (int a = 0; a < 6; a++) rd_chk(4'(a), 16'h0000);
    wr_reg(4'h2, 16'hDF5F);
    rd_chk(4'h2, 16'h9F1F);
    wr_reg(4'h2, 16'h0000);
    wr_reg(4'h4, 16'h0001);
    wr_reg(4'h0, 16'h00A1);
    wait_pend(6'h01);
    rd_chk(4'h0, 16'h00C1);
    wait_pend(6'h00, 6'h01);
    chk({15'h0000, irq}, 16'h0001);
    rd_chk(4'h3, 16'h0001);
    wr_reg(4'h3, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(4'h4, 16'h0000);
    wr_reg(4'h0, 16'h0023);
    rd_chk(4'h0, 16'h0023);
    wr_reg(4'h0, 16'h0020);
    wait_pend(6'h00);
    dly <= 4'h4;
    wr_reg(4'h0, 16'h0202);
    pulse(src_trig(2));
    wait_pend(6'h03);
    wait_pend(6'h02);
    wait_pend(6'h00);
    for (int c = 3; c < 32; c++) begin
      p = c % 6;
      dly <= (c % 2) ? 4'h2 : 4'h9;
      wr_reg(4'(p / 2), 16'(c) << (8 * (p % 2)));
      pulse(src_trig(c == 31 ? 3 : c + 1));
      wait_pend(6'h00);
      pulse(src_trig(c));
      wait_pend(6'h01 << p);
      wait_pend(6'h00);
      wr_reg(4'(p / 2), 16'h0000);
    end
    rd_chk(4'h3, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
